// *** design/cai_dev.sv ***
// Processor end: hold arbitration, coprocessor handshake, interrupt entry
// and reset behaviour. Assumes far end drives reset_n synchronously.
`timescale 1ns/1ps
module cai_dev
(
  cai_if.dev        pins,
  input wire logic  clk_en,
  input wire logic  if_enable,
  input wire logic  cop_valid,
  input wire cai_pkg::cai_cop_t cop_class,
  input wire logic  interrupt_return_instr_exec,
  output logic      cop_go,
  output logic      exc_valid,
  output logic [7:0] exc_vector,
  output logic      operand_xfer,
  output logic      self_test,
  output logic      clk_phase,
  output logic      in_hold
);
  // Async input bank: operand req, busy_n, error_n, irq, nmi
  localparam int NSYNC = 5;
  // Busy and error rest high, so reset shows no false busy or error
  localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h06;
  localparam logic [1:0]       ACKL_1    = cai_pkg::ACK_LEN - 2'h1;
  wire  [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic             rst_seen_r;
  logic             busy_at_rst_r;
  logic             nmi_prev_r;
  logic             nmi_pend_r;
  logic             nmi_block_r;
  logic [1:0]       ack_cnt_r;
  cai_pkg::cai_state_t state_r;
  cai_pkg::cai_state_t state_nxt;

  assign async_in = {pins.nmi, pins.maskable_irq, pins.coproc_error_n,
                     pins.coproc_busy_n, pins.coproc_operand_request};

  // Two flops per input; only second stage is looked at, except raw busy_n sampled for self-test
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge pins.clk or negedge pins.reset_n)
      begin
        if (!pins.reset_n)
        begin
          meta_r[g] <= SYNC_IDLE[g];
          sync_r[g] <= SYNC_IDLE[g];
        end
        else if (clk_en)
        begin
          meta_r[g] <= async_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  wire oper_req  = sync_r[0];
  wire busy_now  = !sync_r[1];
  wire error_now = !sync_r[2];
  wire irq_now   = sync_r[3];
  wire nmi_now   = sync_r[4];
  wire nmi_rise  = nmi_now && !nmi_prev_r;

  // Class decodes
  function automatic logic skips_busy(input cai_pkg::cai_cop_t c);
    skips_busy = (c == cai_pkg::COP_INIT) || (c == cai_pkg::COP_CLEX);
  endfunction : skips_busy

  function automatic logic skips_error(input cai_pkg::cai_cop_t c);
    skips_error = (c != cai_pkg::COP_STACK) && (c != cai_pkg::COP_WAIT);
  endfunction : skips_error

  wire in_hold_st   = (state_r == cai_pkg::ST_HOLD);
  wire idle_st      = (state_r == cai_pkg::ST_IDLE);
  wire cop_err_hit  = idle_st && cop_valid && error_now
                      && !skips_error(cop_class);
  wire cop_wait     = cop_valid && busy_now
                      && !skips_busy(cop_class);
  wire cop_ok       = idle_st && cop_valid && !cop_wait && !cop_err_hit;
  wire nmi_take     = idle_st && nmi_pend_r && !nmi_block_r
                      && !pins.hold_request;
  wire irq_take     = idle_st && irq_now && if_enable && !nmi_take
                      && !pins.hold_request;

  // Next-state choice; hold has priority, then NMI, then maskable
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      cai_pkg::ST_IDLE:
        if (pins.hold_request)
          state_nxt = cai_pkg::ST_HOLD;
        else if (nmi_take)
          state_nxt = cai_pkg::ST_NMI;
        else if (irq_take)
          state_nxt = cai_pkg::ST_ACK1;
        else if (oper_req)
          state_nxt = cai_pkg::ST_OPER;
        else if (cop_valid && cop_wait)
          state_nxt = cai_pkg::ST_BUSYW;
      cai_pkg::ST_HOLD:
        if (!pins.hold_request)
          state_nxt = cai_pkg::ST_IDLE;
      cai_pkg::ST_ACK1:
        if (ack_cnt_r == ACKL_1)
          state_nxt = cai_pkg::ST_ACK2;
      cai_pkg::ST_ACK2:
        if (ack_cnt_r == ACKL_1)
          state_nxt = cai_pkg::ST_VECT;
      cai_pkg::ST_VECT:  state_nxt = cai_pkg::ST_IDLE;
      cai_pkg::ST_NMI:   state_nxt = cai_pkg::ST_IDLE;
      cai_pkg::ST_OPER:  state_nxt = cai_pkg::ST_IDLE;
      cai_pkg::ST_BUSYW:
        if (!busy_now)
          state_nxt = cai_pkg::ST_IDLE;
      default:           state_nxt = cai_pkg::ST_IDLE;
    endcase
  end

  // Reset wins over hold: state forced idle asynchronously
  always_ff @(posedge pins.clk or negedge pins.reset_n)
  begin
    if (!pins.reset_n)
    begin
      state_r    <= cai_pkg::ST_IDLE;
      ack_cnt_r  <= 2'h0;
      nmi_prev_r <= 1'b0;
      exc_valid  <= 1'b0;
      exc_vector <= 8'h00;
      cop_go     <= 1'b0;
      operand_xfer <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r    <= state_nxt;
      nmi_prev_r <= nmi_now;
      ack_cnt_r  <= (state_nxt != state_r) ? 2'h0 : ack_cnt_r + 2'h1;
      exc_valid  <= cop_err_hit || (state_r == cai_pkg::ST_VECT)
                    || (state_r == cai_pkg::ST_NMI);
      if (cop_err_hit)
        exc_vector <= cai_pkg::COPROC_ERR_VECTOR;
      else if (state_r == cai_pkg::ST_ACK2 && state_nxt == cai_pkg::ST_VECT)
        exc_vector <= pins.data_in[7:0];
      else if (state_r == cai_pkg::ST_NMI)
        exc_vector <= cai_pkg::NMI_VECTOR;
      cop_go       <= cop_ok && !oper_req && !nmi_take && !irq_take
                      && !pins.hold_request;
      operand_xfer <= (state_nxt == cai_pkg::ST_OPER)
                      && (state_r != cai_pkg::ST_OPER);
    end
  end

  // NMI memory: one edge pending, blocked until return
  always_ff @(posedge pins.clk or negedge pins.reset_n)
  begin
    if (!pins.reset_n)
    begin
      nmi_pend_r  <= 1'b0;
      nmi_block_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (nmi_rise)
        nmi_pend_r <= 1'b1;
      else if (nmi_take)
        nmi_pend_r <= 1'b0;
      if (nmi_take)
        nmi_block_r <= 1'b1;
      else if (interrupt_return_instr_exec)
        nmi_block_r <= 1'b0;
    end
  end

  // Busy caught on first enabled edge after reset release; phase restarts
  always_ff @(posedge pins.clk or negedge pins.reset_n)
  begin
    if (!pins.reset_n)
    begin
      rst_seen_r    <= 1'b0;
      busy_at_rst_r <= 1'b0;
      clk_phase     <= 1'b0;
    end
    else if (clk_en)
    begin
      rst_seen_r <= 1'b1;
      clk_phase  <= ~clk_phase;
      if (!rst_seen_r)
        busy_at_rst_r <= !pins.coproc_busy_n;
    end
  end
  assign self_test = busy_at_rst_r;

  // Pin levels: hold floats everything but acknowledge
  wire in_ack = (state_r == cai_pkg::ST_ACK1)
                || (state_r == cai_pkg::ST_ACK2);
  assign in_hold                    = in_hold_st;
  assign pins.bus_release_ack       = in_hold_st;
  assign pins.bus_ctl_oe_n          = in_hold_st;
  assign pins.cycle_start_strobe_oe_n = in_hold_st;
  assign pins.data_oe_n             = 1'b1;
  assign pins.data_out              = 32'h00000000;
  assign pins.cycle_start_strobe_n  = !(in_ack && ack_cnt_r == 2'h0);
  assign pins.byte_lane_selects_n   = cai_pkg::IDLE_LANES_N;
  assign pins.addr                  = cai_pkg::IDLE_ADDR;
  assign pins.write_sel             = cai_pkg::IDLE_WRITE;
  assign pins.data_ctl_sel          = in_ack ? 1'b0 : cai_pkg::IDLE_DATA_CTL;
  assign pins.mem_io_sel            = cai_pkg::IDLE_MEM_IO;
  assign pins.lock_n                = cai_pkg::IDLE_LOCK_N;
endmodule : cai_dev

// *** design/cai_pkg.sv ***
// Package for the processor control-input block: arbitration, coprocessor
// handshake, interrupts and reset. Shared by both ends and the checker.
// Assumes one clock (the double-rate clock) for every party.
package cai_pkg;
  // Bus pin idle levels during reset
  localparam logic       IDLE_STROBE_N = 1'b1;
  localparam logic [3:0] IDLE_LANES_N  = 4'h0;
  localparam logic [29:0] IDLE_ADDR    = 30'h3FFFFFFF;
  localparam logic       IDLE_WRITE    = 1'b0;
  localparam logic       IDLE_DATA_CTL = 1'b1;
  localparam logic       IDLE_MEM_IO   = 1'b0;
  localparam logic       IDLE_LOCK_N   = 1'b1;
  // Exception and table slots
  localparam logic [7:0] COPROC_ERR_VECTOR = 8'h10;
  localparam logic [7:0] NMI_VECTOR        = 8'h02;
  // Timing counts in clock periods
  localparam int NMI_LOW_CYCLES     = 8;
  localparam int NMI_HIGH_CYCLES    = 8;
  localparam int RESET_MIN_CYCLES   = 15;
  localparam int RESET_BIST_CYCLES  = 80;
  localparam int ACK_CYCLE_LEN      = 2;
  localparam logic [1:0] ACK_LEN    = 2'h2;

  // Coprocessor instruction classes
  typedef enum logic [2:0]
  {
    COP_STACK   = 3'h0,
    COP_WAIT    = 3'h1,
    COP_INIT    = 3'h2,
    COP_CLEX    = 3'h3,
    COP_STSW    = 3'h4,
    COP_STCW    = 3'h5,
    COP_STENV   = 3'h6,
    COP_SAVE    = 3'h7
  } cai_cop_t;

  // Device control state, Gray along idle-ack1-ack2-vector
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ACK1  = 3'b001,
    ST_ACK2  = 3'b011,
    ST_VECT  = 3'b010,
    ST_HOLD  = 3'b110,
    ST_NMI   = 3'b111,
    ST_OPER  = 3'b101,
    ST_BUSYW = 3'b100
  } cai_state_t;
endpackage : cai_pkg

// *** design/cai_if.sv ***
// Interface joining processor end and far end of the control inputs.
// Bus pins are split into output, enable (low = driven) and input.
`timescale 1ns/1ps
interface cai_if
(
  input wire logic clk
);
  logic        reset_n;
  logic        hold_request;
  logic        bus_release_ack;
  logic        coproc_operand_request;
  logic        coproc_busy_n;
  logic        coproc_error_n;
  logic        maskable_irq;
  logic        nmi;
  logic        cycle_start_strobe_n;
  logic        cycle_start_strobe_oe_n;
  logic [3:0]  byte_lane_selects_n;
  logic [29:0] addr;
  logic        write_sel;
  logic        data_ctl_sel;
  logic        mem_io_sel;
  logic        lock_n;
  logic        bus_ctl_oe_n;
  logic [31:0] data_out;
  logic        data_oe_n;
  logic [31:0] data_in;

  modport dev
  (
    input  clk, reset_n, hold_request, coproc_operand_request,
           coproc_busy_n, coproc_error_n, maskable_irq, nmi, data_in,
    output bus_release_ack, cycle_start_strobe_n, cycle_start_strobe_oe_n,
           byte_lane_selects_n, addr, write_sel, data_ctl_sel, mem_io_sel,
           lock_n, bus_ctl_oe_n, data_out, data_oe_n
  );
  modport far
  (
    input  clk, bus_release_ack, cycle_start_strobe_n, byte_lane_selects_n,
           addr, write_sel, data_ctl_sel, mem_io_sel, lock_n, bus_ctl_oe_n,
           data_out, data_oe_n,
    output reset_n, hold_request, coproc_operand_request, coproc_busy_n,
           coproc_error_n, maskable_irq, nmi, data_in
  );
endinterface : cai_if

// *** design/cai_far.sv ***
// Far end: reset generator, hold requester, NMI shaper and vector source.
// Assumes user-side requests are synchronous to clk.
`timescale 1ns/1ps
module cai_far
(
  cai_if.far        pins,
  input wire logic  reset_n,
  input wire logic  clk_en,
  input wire logic  want_bus,
  input wire logic  want_bist,
  input wire logic  cop_busy,
  input wire logic  cop_error,
  input wire logic  cop_operand,
  input wire logic  irq_req,
  input wire logic  nmi_req,
  input wire logic [7:0] irq_vector,
  output logic      bus_owned,
  output logic      reset_done
);
  logic [6:0] rst_cnt_r;
  logic       hold_r;
  logic       irq_r;
  logic       nmi_r;
  logic [3:0] nmi_cnt_r;
  logic       strap_done_r;

  wire [6:0] rst_need = want_bist ? 7'(cai_pkg::RESET_BIST_CYCLES)
                                  : 7'(cai_pkg::RESET_MIN_CYCLES);
  wire [3:0] nmi_need = 4'(cai_pkg::NMI_HIGH_CYCLES);
  wire       ack_start = !pins.cycle_start_strobe_n && !pins.data_ctl_sel;

  always_ff @(posedge pins.clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_cnt_r  <= 7'h00;
      hold_r     <= 1'b0;
      irq_r      <= 1'b0;
      nmi_r      <= 1'b0;
      nmi_cnt_r  <= 4'h0;
      strap_done_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rst_cnt_r < rst_need)
        rst_cnt_r <= rst_cnt_r + 7'h01;
      hold_r <= want_bus || (hold_r && pins.bus_release_ack
                && want_bus);
      if (irq_req)
        irq_r <= 1'b1;
      else if (ack_start)
        irq_r <= 1'b0;
      // Strap outlives release by one cycle: device samples it then
      strap_done_r <= reset_done;
      // NMI pulse stretched to eight high, then at least nine low
      if (nmi_cnt_r != 4'h0)
        nmi_cnt_r <= nmi_cnt_r - 4'h1;
      else if (nmi_r)
      begin
        nmi_r     <= 1'b0;
        nmi_cnt_r <= 4'(cai_pkg::NMI_LOW_CYCLES);
      end
      else if (nmi_req)
      begin
        nmi_r     <= 1'b1;
        nmi_cnt_r <= nmi_need - 4'h1;
      end
    end
  end

  assign reset_done                 = (rst_cnt_r >= rst_need);
  assign pins.reset_n               = reset_done;
  assign pins.hold_request          = hold_r && reset_done;
  assign pins.coproc_busy_n         = strap_done_r ? !cop_busy : !want_bist;
  assign pins.coproc_error_n        = !cop_error;
  assign pins.coproc_operand_request = cop_operand;
  assign pins.maskable_irq          = irq_r;
  assign pins.nmi                   = nmi_r;
  assign pins.data_in               = {24'h000000, irq_vector};
  assign bus_owned                  = pins.bus_release_ack;
endmodule : cai_far

// *** tb/cai_link_checker.sv ***
// Checker on the signals that join processor end and far end.
// Assumes one clock; instantiated beside the interface, no bind.
`timescale 1ns/1ps
module cai_link_checker
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hold_request,
  input wire logic        bus_release_ack,
  input wire logic        cycle_start_strobe_n,
  input wire logic        cycle_start_strobe_oe_n,
  input wire logic [3:0]  byte_lane_selects_n,
  input wire logic [29:0] addr,
  input wire logic        write_sel,
  input wire logic        data_ctl_sel,
  input wire logic        mem_io_sel,
  input wire logic        lock_n,
  input wire logic        bus_ctl_oe_n,
  input wire logic        data_oe_n
);
  // No disable here: reset itself is the cause
  chk_reset_bus_idle:
  assert property (@(posedge clk) !reset_n |-> cycle_start_strobe_n
    && byte_lane_selects_n == cai_pkg::IDLE_LANES_N
    && addr == cai_pkg::IDLE_ADDR)
    else $error("bus pins not idle in reset");
  chk_reset_ctl_idle:
  assert property (@(posedge clk) !reset_n |-> !write_sel && data_ctl_sel
    && !mem_io_sel && lock_n)
    else $error("control pins not idle in reset");
  chk_reset_no_hold:
  assert property (@(posedge clk) !reset_n |-> !bus_release_ack && data_oe_n)
    else $error("hold or data driven in reset");
  chk_ack_after_req:
  assert property (@(posedge clk) disable iff (!reset_n)
    bus_release_ack |-> $past(hold_request))
    else $error("acknowledge without request");
  chk_ack_release:
  assert property (@(posedge clk) disable iff (!reset_n)
    bus_release_ack && !hold_request |=> !bus_release_ack)
    else $error("acknowledge kept after request gone");
  chk_ack_stands:
  assert property (@(posedge clk) disable iff (!reset_n)
    bus_release_ack && hold_request |=> bus_release_ack)
    else $error("acknowledge dropped while requested");
  chk_hold_float:
  assert property (@(posedge clk) disable iff (!reset_n) bus_release_ack
    |-> bus_ctl_oe_n && cycle_start_strobe_oe_n && data_oe_n)
    else $error("bus driven in hold");
  chk_bus_driven:
  assert property (@(posedge clk) disable iff (!reset_n) !bus_release_ack
    |-> !bus_ctl_oe_n && !cycle_start_strobe_oe_n)
    else $error("bus floated outside hold");
endmodule : cai_link_checker

// *** tb/tb_top.sv ***
// Bench joining both ends through the interface, driving user sides.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic want_bus = 1'b0, want_bist = 1'b0, cop_busy = 1'b1;
  logic cop_error = 1'b0, cop_operand = 1'b0, irq_req = 1'b0;
  logic nmi_req = 1'b0, if_enable = 1'b0, cop_valid = 1'b0;
  logic interrupt_return_instr_exec = 1'b0;
  logic [7:0] irq_vector = 8'h00;
  cai_pkg::cai_cop_t cop_class = cai_pkg::COP_STACK;
  logic cop_go, exc_valid, operand_xfer, self_test, in_hold;
  logic bus_owned, reset_done, got_exc, got_go, got_op, prev_strobe;
  logic [7:0] exc_vector, vec;
  int bad_count = 0;
  int num_checks = 0;
  int strobes;
  // Rows: class, busy, error, expect response, expect exception
  localparam logic [6:0] ROWS [12] = '{7'h07, 7'h17, 7'h26, 7'h36,
    7'h46, 7'h56, 7'h66, 7'h76, 7'h08, 7'h18, 7'h2A, 7'h3A};

  always #2.5 clk = ~clk;

  cai_if i_cai_if (.clk(clk));
  cai_dev i_cai_dev (.pins(i_cai_if), .clk_en(1'b1), .if_enable(if_enable),
    .cop_valid(cop_valid), .cop_class(cop_class), .interrupt_return_instr_exec(interrupt_return_instr_exec),
    .cop_go(cop_go), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .operand_xfer(operand_xfer), .self_test(self_test), .clk_phase(),
    .in_hold(in_hold));
  cai_far i_cai_far (.pins(i_cai_if), .reset_n(reset_n), .clk_en(1'b1),
    .want_bus(want_bus), .want_bist(want_bist), .cop_busy(cop_busy),
    .cop_error(cop_error), .cop_operand(cop_operand), .irq_req(irq_req),
    .nmi_req(nmi_req), .irq_vector(irq_vector), .bus_owned(bus_owned),
    .reset_done(reset_done));
  cai_link_checker i_cai_link_checker (.clk(clk),
    .reset_n(i_cai_if.reset_n), .hold_request(i_cai_if.hold_request),
    .bus_release_ack(i_cai_if.bus_release_ack),
    .cycle_start_strobe_n(i_cai_if.cycle_start_strobe_n),
    .cycle_start_strobe_oe_n(i_cai_if.cycle_start_strobe_oe_n),
    .byte_lane_selects_n(i_cai_if.byte_lane_selects_n),
    .addr(i_cai_if.addr), .write_sel(i_cai_if.write_sel),
    .data_ctl_sel(i_cai_if.data_ctl_sel), .mem_io_sel(i_cai_if.mem_io_sel),
    .lock_n(i_cai_if.lock_n), .bus_ctl_oe_n(i_cai_if.bus_ctl_oe_n),
    .data_oe_n(i_cai_if.data_oe_n));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : check

  // operand_xfer and the vector and NMI exc_valid stand one cycle, so every cycle is looked at
  task automatic watch(input int lim, input bit keep = 1'b0);
    if (!keep)
    begin
      got_exc = 1'b0;
      got_go = 1'b0;
      got_op = 1'b0;
      strobes = 0;
    end
    repeat (lim)
    begin
      prev_strobe = i_cai_if.cycle_start_strobe_n;
      @(posedge clk);
      #1;
      if (exc_valid === 1'b1)
      begin
        got_exc = 1'b1;
        vec = exc_vector;
      end
      if (cop_go === 1'b1) got_go = 1'b1;
      if (operand_xfer === 1'b1) got_op = 1'b1;
      if (prev_strobe === 1'b1 && i_cai_if.cycle_start_strobe_n === 1'b0)
        strobes++;
    end
  endtask : watch

  task automatic do_reset(input logic bist, input logic busy);
    int n;
    n = 5;
    want_bist = bist;
    cop_busy = busy;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(8'(i_cai_if.bus_release_ack), 8'h00);
    reset_n = 1'b1;
    while (i_cai_if.reset_n !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(8'(n >= (bist ? 80 : 15)), 8'h01);
    watch(4);
    check(8'(self_test), 8'(bist));
    check(8'(reset_done), 8'h01);
    cop_busy = 1'b0;
    want_bist = 1'b0;
  endtask : do_reset

  task automatic pulse_interrupt_return_instr;
    interrupt_return_instr_exec = 1'b1;
    @(posedge clk);
    #1;
    interrupt_return_instr_exec = 1'b0;
  endtask : pulse_interrupt_return_instr

  task end_sim;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  initial
  begin
    #100000;
    bad_count++;
    end_sim;
  end

  initial
  begin
    do_reset(1'b0, 1'b1);
    for (int i = 0; i < 12; i++)
    begin
      cop_busy = ROWS[i][3];
      cop_error = ROWS[i][2];
      watch(4);
      cop_class = cai_pkg::cai_cop_t'(ROWS[i][6:4]);
      cop_valid = 1'b1;
      watch(12);
      cop_valid = 1'b0;
      cop_busy = 1'b0;
      cop_error = 1'b0;
      check(8'(got_go | got_exc), 8'(ROWS[i][1]));
      check(8'(got_exc), 8'(ROWS[i][0]));
      if (ROWS[i][0]) check(vec, cai_pkg::COPROC_ERR_VECTOR);
      watch(10);
    end
    want_bus = 1'b1;
    watch(6);
    check({6'h00, in_hold, bus_owned}, 8'h03);
    nmi_req = 1'b1;
    watch(30);
    check(8'(got_exc), 8'h00);
    nmi_req = 1'b0;
    want_bus = 1'b0;
    watch(30);
    check(8'(got_exc), 8'h01);
    check(vec, cai_pkg::NMI_VECTOR);
    check(8'(strobes), 8'h00);
    nmi_req = 1'b1;
    watch(30);
    nmi_req = 1'b0;
    watch(20, 1'b1);
    check(8'(got_exc), 8'h00);
    pulse_interrupt_return_instr();
    watch(30);
    check(8'(got_exc), 8'h01);
    check(vec, cai_pkg::NMI_VECTOR);
    pulse_interrupt_return_instr();
    irq_vector = 8'h5A;
    // One-cycle request: far end holds it until the first ack starts
    irq_req = 1'b1;
    watch(1);
    irq_req = 1'b0;
    watch(30);
    check(8'(got_exc), 8'h00);
    if_enable = 1'b1;
    watch(25);
    check(8'(got_exc), 8'h01);
    check(vec, 8'h5A);
    check(8'(strobes), 8'h02);
    cop_operand = 1'b1;
    watch(10);
    cop_operand = 1'b0;
    check(8'(got_op), 8'h01);
    want_bus = 1'b1;
    watch(6);
    do_reset(1'b1, 1'b0);
    end_sim;
  end
endmodule : tb_top
